//--- rtl/xbus_rtc_select_and_buffer_control.v
// peripheral-bus control outputs: processor init, clock-chip strobes, buffer direction
// assumes ISA command pins asynchronous to i_clk; address and decode inputs stable
// while a command is low; i_sysclk is the ISA system clock, sampled as a pin
// Function
// (RULE_01) keyboard reset request low drives processor init request
// (RULE_02) i/o write to 70h asserts clock-chip index strobe
// (RULE_03) strobe rises at write fall, lasts exactly two system clocks; the code ends it at the second system clock rise
// (RULE_04) index strobe low during and after reset and in suspend
// (RULE_05) strobe and chip select can become general-purpose outputs
// (RULE_06) chip select low for i/o read or write to 71h
// (RULE_07) board may OR chip select with commands for chip strobes
// (RULE_08) chip select and direction high in reset and suspend
// (RULE_09) direction output wires straight to transceiver direction input
// (RULE_10) direction low for every i/o read cycle
// (RULE_11) memory cycles turn direction only for rom or controller range
// (RULE_12) pci master reads assert on i/o read or decoded memory read fall
// (RULE_13) isa master memory reads qualify only on firmware rom range
// (RULE_14) direction negates at rise of the causing read command
// (RULE_15) dma reads: direction follows acknowledge fall and rise
// (RULE_16) otherwise direction held high
// (RULE_17) direction can become a general-purpose output
// (RULE_18) pins default to dedicated function; gpo value from writable bit
`default_nettype none
`include "xbus_ctl_regs.vh"
module xbus_rtc_select_and_buffer_control #(
    parameter ADDR_W = 16
) (
    input  wire              i_clk,                    // 25 MHz clock
    input  wire              i_sys_rst,                // sync reset, high
    input  wire              i_suspend,                // power-on suspend
    input  wire              i_sysclk,                 // ISA system clock pin
    input  wire              i_kbd_cpu_reset_request_n,// keyboard reset request
    input  wire              i_ior_n,                  // i/o read command
    input  wire              i_iow_n,                  // i/o write command
    input  wire              i_memr_n,                 // memory read command
    input  wire [ADDR_W-1:0] i_addr,                   // ISA address
    input  wire              i_isa_master,             // cycle from isa master
    input  wire              i_firmware_rom_range,     // rom range decoded
    input  wire              i_interrupt_controller_range, // controller range
    input  wire              i_dma_read_ack_n,         // dma read acknowledge
    input  wire              i_gpo_sel_25,             // index strobe as gpo
    input  wire              i_gpo_sel_24,             // chip select as gpo
    input  wire              i_gpo_sel_22,             // direction as gpo
    input  wire              i_general_output_25,      // gpo value 25
    input  wire              i_general_output_24,      // gpo value 24
    input  wire              i_general_output_22,      // gpo value 22
    output reg               o_cpu_init,               // processor init request
    output reg               o_clock_chip_index_strobe,// index latch strobe
    output reg               o_clock_chip_select_n,    // clock chip select
    output reg               o_periph_buffer_direction_n // transceiver direction
);
    localparam ST_IDLE = 2'd0;
    localparam ST_IOR  = 2'd1;
    localparam ST_MEMR = 2'd2;
    localparam ST_DMA  = 2'd3;

    wire ior_lvl, ior_fall, ior_rise;
    wire iow_lvl, iow_fall;
    wire memr_fall, memr_rise;
    wire dack_fall, dack_rise;
    wire sclk_rise;
    wire kbd_lvl;

    edge_sync #(.RST_VAL(1'b1)) u_ior (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_async(i_ior_n), .o_level(ior_lvl), .o_fall(ior_fall), .o_rise(ior_rise));
    edge_sync #(.RST_VAL(1'b1)) u_iow (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_async(i_iow_n), .o_level(iow_lvl), .o_fall(iow_fall), .o_rise());
    edge_sync #(.RST_VAL(1'b1)) u_memr (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_async(i_memr_n), .o_level(), .o_fall(memr_fall), .o_rise(memr_rise));
    edge_sync #(.RST_VAL(1'b1)) u_dack (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_async(i_dma_read_ack_n), .o_level(), .o_fall(dack_fall),
        .o_rise(dack_rise));
    edge_sync #(.RST_VAL(1'b0)) u_sclk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_async(i_sysclk), .o_level(), .o_fall(), .o_rise(sclk_rise));
    edge_sync #(.RST_VAL(1'b1)) u_kbd (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_async(i_kbd_cpu_reset_request_n), .o_level(kbd_lvl), .o_fall(),
        .o_rise());

    // port match, reused for both clock-chip ports
    function port_hit;
        input [ADDR_W-1:0] a;
        input [15:0]       p;
        begin
            port_hit = (a == p[ADDR_W-1:0]);
        end
    endfunction

    // address and decodes pass the same two flops as the commands, so they line up
    // with the detected command edges; the bus sets them up ahead of the command
    reg  [ADDR_W+2:0] qual_meta_q;
    reg  [ADDR_W+2:0] qual_sync_q;
    wire [ADDR_W-1:0] addr_s       = qual_sync_q[ADDR_W-1:0];
    wire              rom_range_s  = qual_sync_q[ADDR_W];
    wire              ctl_range_s  = qual_sync_q[ADDR_W+1];
    wire              isa_master_s = qual_sync_q[ADDR_W+2];

    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            qual_meta_q <= {(ADDR_W+3){1'b0}};
            qual_sync_q <= {(ADDR_W+3){1'b0}};
        end
        else
        begin
            qual_meta_q <= {i_isa_master, i_interrupt_controller_range,
                            i_firmware_rom_range, i_addr};
            qual_sync_q <= qual_meta_q;
        end
    end

    reg       strobe_q;
    reg       strobe_d;
    reg [3:0] sclk_cnt_q;
    reg [3:0] sclk_cnt_d;
    reg [1:0] dir_st_q;
    reg [1:0] dir_st_d;
    wire      index_hit = port_hit(addr_s, `CLOCK_CHIP_INDEX_PORT);
    wire      data_hit  = port_hit(addr_s, `CLOCK_CHIP_DATA_PORT);
    // isa masters ignore the controller range on memory reads
    wire      mem_ok = rom_range_s |
                       (ctl_range_s & ~isa_master_s);

    always @*
    begin
        strobe_d   = strobe_q;
        sclk_cnt_d = sclk_cnt_q;
        // (RULE_02) index write starts strobe
        // (RULE_03) rise on write fall
        // a new index write restarts the count and wins over the end of the last one
        if (iow_fall && index_hit)
        begin
            strobe_d   = 1'b1;
            sclk_cnt_d = 4'h0;
        end
        else if (strobe_q && sclk_rise)
        begin
            // (RULE_03) two system clocks
            if (sclk_cnt_q == `INDEX_STROBE_SYSCLKS - 4'h1)
                strobe_d = 1'b0;
            else
                sclk_cnt_d = sclk_cnt_q + 4'h1;
        end
    end

    always @*
    begin
        dir_st_d = dir_st_q;
        case (dir_st_q)
            // causes arriving while a read is open are dropped, not taken up after it closes
            ST_IDLE:
            begin
                // (RULE_10) every i/o read
                // (RULE_12) pci reads on command fall
                if (ior_fall)
                    dir_st_d = ST_IOR;
                // (RULE_11) memory only on decoded ranges
                // (RULE_13) isa master rom only
                else if (memr_fall && mem_ok)
                    dir_st_d = ST_MEMR;
                // (RULE_15) dma acknowledge fall
                else if (dack_fall)
                    dir_st_d = ST_DMA;
            end
            // (RULE_14) negate on causing command rise
            ST_IOR:  if (ior_rise)  dir_st_d = ST_IDLE;
            ST_MEMR: if (memr_rise) dir_st_d = ST_IDLE;
            // (RULE_15) acknowledge rise
            ST_DMA:  if (dack_rise) dir_st_d = ST_IDLE;
            default: dir_st_d = ST_IDLE;
        endcase
    end

    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            strobe_q   <= `INDEX_STROBE_RST;
            sclk_cnt_q <= 4'h0;
            dir_st_q   <= ST_IDLE;
        end
        else
        begin
            strobe_q   <= strobe_d;
            sclk_cnt_q <= sclk_cnt_d;
            dir_st_q   <= dir_st_d;
        end
    end

    // registered pin drive
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            o_cpu_init                  <= 1'b0;
            // (RULE_04) strobe low in reset
            o_clock_chip_index_strobe   <= `INDEX_STROBE_RST;
            // (RULE_08) select and direction high
            o_clock_chip_select_n       <= `CHIP_SELECT_RST;
            o_periph_buffer_direction_n <= `DIRECTION_RST;
        end
        else
        begin
            // (RULE_01) request becomes init
            o_cpu_init <= ~kbd_lvl;
            // (RULE_05) gpo option
            // (RULE_18) dedicated function unless selected
            if (i_gpo_sel_25)
                o_clock_chip_index_strobe <= i_general_output_25;
            // (RULE_04) low in suspend
            else
                o_clock_chip_index_strobe <= strobe_d & ~i_suspend;
            if (i_gpo_sel_24)
                o_clock_chip_select_n <= i_general_output_24;
            // (RULE_06) data port read or write
            // (RULE_08) high in suspend
            else
                o_clock_chip_select_n <= ~(data_hit & (~ior_lvl | ~iow_lvl)) | i_suspend;
            // (RULE_17) direction as gpo
            if (i_gpo_sel_22)
                o_periph_buffer_direction_n <= i_general_output_22;
            // (RULE_16) high outside read cases
            else
                o_periph_buffer_direction_n <= (dir_st_d == ST_IDLE) | i_suspend;
        end
    end
endmodule // xbus_rtc_select_and_buffer_control
`default_nettype wire

//--- rtl/xbus_ctl_regs.vh
// constants for the peripheral-bus control block
// assumes inclusion by bare name from rtl/
`ifndef XBUS_CTL_REGS_VH
`define XBUS_CTL_REGS_VH
`define CLOCK_CHIP_INDEX_PORT 16'h0070
`define CLOCK_CHIP_DATA_PORT  16'h0071
`define INDEX_STROBE_SYSCLKS  4'h2
`define INDEX_STROBE_RST      1'b0
`define CHIP_SELECT_RST       1'b1
`define DIRECTION_RST         1'b1
`endif

//--- rtl/edge_sync.v
// two-flop synchroniser with fall and rise pulses
// assumes one clock i_clk and synchronous active-high reset
`default_nettype none
module edge_sync #(
    parameter RST_VAL = 1'b1
) (
    input  wire i_clk,     // clock
    input  wire i_sys_rst, // reset
    input  wire i_async,   // pin input
    output wire o_level,   // synchronised level
    output wire o_fall,    // one-cycle falling pulse
    output wire o_rise     // one-cycle rising pulse
);
    reg meta_q;
    reg sync_q;
    reg prev_q;
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
            prev_q <= RST_VAL;
        end
        else
        begin
            meta_q <= i_async;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end
    assign o_level = sync_q;
    assign o_fall  = prev_q & ~sync_q;
    assign o_rise  = ~prev_q & sync_q;
endmodule // edge_sync
`default_nettype wire

//--- tb/xbus_ctl_chk.sv
// checker for the peripheral-bus control outputs
// assumes commands and decodes held steady for several clocks
`default_nettype none
module xbus_ctl_chk (
    input wire logic        i_clk,                        // clock
    input wire logic        i_sys_rst,                    // reset, high
    input wire logic        i_suspend,                    // power-on suspend
    input wire logic        i_kbd_cpu_reset_request_n,    // keyboard reset request
    input wire logic        i_ior_n,                      // i/o read
    input wire logic        i_iow_n,                      // i/o write
    input wire logic        i_memr_n,                     // memory read
    input wire logic        i_dma_read_ack_n,             // dma read acknowledge
    input wire logic [15:0] i_addr,                       // isa address
    input wire logic        i_isa_master,                 // isa master cycle
    input wire logic        i_firmware_rom_range,         // rom range decode
    input wire logic        i_interrupt_controller_range, // controller range decode
    input wire logic        i_gpo_sel_22,                 // direction as gpo
    input wire logic        i_gpo_sel_24,                 // select as gpo
    input wire logic        i_gpo_sel_25,                 // strobe as gpo
    input wire logic        o_cpu_init,                   // init request
    input wire logic        o_clock_chip_index_strobe,    // index strobe
    input wire logic        o_clock_chip_select_n,        // chip select
    input wire logic        o_periph_buffer_direction_n   // buffer direction
);
    wire stb    = o_clock_chip_index_strobe;
    wire dir    = o_periph_buffer_direction_n;
    wire gp     = i_gpo_sel_22 || i_gpo_sel_24 || i_gpo_sel_25;
    wire ded    = !i_suspend && !gp;
    wire idl    = i_ior_n && i_memr_n && i_dma_read_ack_n;
    wire rd_io  = !i_ior_n && i_memr_n && i_dma_read_ack_n;
    wire rd_dma = !i_dma_read_ack_n && i_ior_n && i_memr_n;
    wire rd_mem = !i_memr_n && i_ior_n && i_dma_read_ack_n;
    wire no_dec = !i_firmware_rom_range && (i_isa_master || !i_interrupt_controller_range);
    wire wr_idx = !i_iow_n && i_addr == 16'h0070;
    wire cs_hit = (!i_ior_n || !i_iow_n) && i_addr == 16'h0071;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    a_init_follows_req: assert property (($stable(i_kbd_cpu_reset_request_n))[*5]
        |-> o_cpu_init == !i_kbd_cpu_reset_request_n) else $error("init level");
    a_strobe_cause: assert property ($rose(stb) && ded |-> wr_idx)
        else $error("strobe cause");
    a_strobe_width: assert property ($rose(stb) && ded |-> stb[*5] ##[1:20] !stb)
        else $error("strobe width");
    a_suspend_idle: assert property ((i_suspend && !gp)[*4]
        |-> !stb && o_clock_chip_select_n && dir) else $error("suspend levels");
    a_select_hit: assert property ((cs_hit && ded)[*5] |-> !o_clock_chip_select_n)
        else $error("select");
    a_dir_ioread: assert property ((rd_io && ded)[*5] |-> !dir)
        else $error("io read direction");
    a_dir_dma: assert property ((rd_dma && ded)[*5] |-> !dir)
        else $error("dma direction");
    a_dir_idle: assert property ((idl && ded)[*5] |-> dir)
        else $error("idle direction");
    a_mem_unqual: assert property ((rd_mem && no_dec && ded)[*5] |-> dir)
        else $error("memory direction");
    a_dir_memread: assert property ((rd_mem && !no_dec && ded)[*5] |-> !dir)
        else $error("memory read direction");
    c_strobe: cover property ($rose(stb));
    c_select: cover property ($fell(o_clock_chip_select_n));
    c_read: cover property ($fell(dir));
    c_dma: cover property ($fell(dir) && !i_dma_read_ack_n);
endmodule // xbus_ctl_chk
`default_nettype wire

//--- tb/rtc_model.sv
// clock chip and transceiver stand-in on the peripheral bus
// assumes the board gates select with the commands
`default_nettype none
module rtc_model (
    input  wire logic i_cs_n,     // clock chip select
    input  wire logic i_ior_n,    // i/o read command
    input  wire logic i_iow_n,    // i/o write command
    input  wire logic i_dir_n,    // transceiver direction
    output logic      o_rd_n,     // chip read strobe
    output logic      o_wr_n,     // chip write strobe
    output logic      o_drives_xd // chip side drives the peripheral bus
);
    assign o_rd_n = i_cs_n | i_ior_n;
    assign o_wr_n = i_cs_n | i_iow_n;
    assign o_drives_xd = !i_dir_n;
endmodule // rtc_model
`default_nettype wire

//--- tb/tb_xbus_rtc_select_and_buffer_control.sv
// bench for the peripheral-bus control block
// assumes rtl on the include path; inputs change at the falling clock edge
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
    $display("unexpected at %0t: got %h exp %h", $time, a, b); end end
module tb_xbus_rtc_select_and_buffer_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 0, rst = 1, susp = 0, req_n = 1, isa = 0, rom = 0, ctl = 0;
    logic [3:0]  cmd = 4'hf; // ior_n iow_n memr_n dack_n
    logic [15:0] addr = 16'h0000;
    logic [2:0]  sel = 3'h0, gval = 3'h0, sck = 3'h0;
    wire         init, stb, cs_n, dir_n, rd_n, wr_n, xd_out;
    int          checks = 0, miscompares = 0, hi_cnt = 0;
    always #20 clk = ~clk;
    always @(negedge clk) sck <= sck + 3'h1;
    xbus_rtc_select_and_buffer_control xbus_rtc_select_and_buffer_control_inst (
        .i_clk(clk), .i_sys_rst(rst), .i_suspend(susp), .i_sysclk(sck[2]),
        .i_kbd_cpu_reset_request_n(req_n), .i_ior_n(cmd[3]), .i_iow_n(cmd[2]),
        .i_memr_n(cmd[1]), .i_addr(addr), .i_isa_master(isa), .i_firmware_rom_range(rom),
        .i_interrupt_controller_range(ctl), .i_dma_read_ack_n(cmd[0]),
        .i_gpo_sel_25(sel[2]), .i_gpo_sel_24(sel[1]), .i_gpo_sel_22(sel[0]),
        .i_general_output_25(gval[2]), .i_general_output_24(gval[1]),
        .i_general_output_22(gval[0]), .o_cpu_init(init), .o_clock_chip_index_strobe(stb),
        .o_clock_chip_select_n(cs_n), .o_periph_buffer_direction_n(dir_n));
    rtc_model rtc_model_inst (.i_cs_n(cs_n), .i_ior_n(cmd[3]), .i_iow_n(cmd[2]),
        .i_dir_n(dir_n), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_drives_xd(xd_out));
    task automatic drive(input logic [3:0] c, input logic [15:0] a);
        @(negedge clk);
        cmd = c;
        addr = a;
        repeat (6) @(negedge clk);
    endtask
    task automatic final_report;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        #40000;
        miscompares++;
        final_report;
    end
    initial
    begin
        repeat (3) @(negedge clk);
        `CHK({init, stb, cs_n, dir_n}, 4'h3)
        rst = 0;
        req_n = 0;
        drive(4'hf, 16'h0000);
        `CHK(init, 1'b1)
        req_n = 1;
        drive(4'hf, 16'h0000);
        `CHK(init, 1'b0)
        drive(4'hb, 16'h0070);
        `CHK({stb, cs_n}, 2'h3)
        drive(4'hf, 16'h0070);
        repeat (18) @(negedge clk);
        `CHK(stb, 1'b0)
        // write launched with a system clock rise: two whole periods of 8 clocks each
        while (sck != 3'h3) @(negedge clk);
        cmd = 4'hb;
        addr = 16'h0070;
        hi_cnt = 0;
        for (int k = 0; k < 30; k++)
        begin
            @(negedge clk);
            hi_cnt += stb;
            if (k == 5)
                cmd = 4'hf;
        end
        `CHK(hi_cnt, 16)
        drive(4'hb, 16'h0071);
        `CHK({cs_n, wr_n, rd_n, stb}, 4'h2)
        drive(4'hf, 16'h0071);
        $display("strobe and select tests done");
        for (int i = 0; i < 2; i++)
        begin
            drive(4'h7, i ? 16'h0080 : 16'h0071);
            `CHK({dir_n, cs_n, xd_out}, {1'b0, i[0], 1'b1})
            drive(4'hf, 16'h0000);
            `CHK(dir_n, 1'b1)
        end
        for (int i = 0; i < 8; i++)
        begin
            {isa, rom, ctl} = i[2:0];
            drive(4'hd, 16'h0000);
            `CHK(dir_n, !(rom || (!isa && ctl)))
            drive(4'hf, 16'h0000);
            `CHK(dir_n, 1'b1)
        end
        drive(4'he, 16'h0000);
        `CHK(dir_n, 1'b0)
        drive(4'hf, 16'h0000);
        `CHK(dir_n, 1'b1)
        $display("direction tests done");
        susp = 1;
        drive(4'h7, 16'h0071);
        `CHK({stb, cs_n, dir_n}, 3'h3)
        drive(4'hf, 16'h0071);
        susp = 0;
        sel = 3'h7;
        gval = 3'h5;
        drive(4'hf, 16'h0000);
        `CHK({stb, cs_n, dir_n}, 3'h5)
        gval = 3'h2;
        drive(4'h7, 16'h0071);
        `CHK({stb, cs_n, dir_n}, 3'h2)
        drive(4'hf, 16'h0071);
        sel = 3'h0;
        $display("suspend and general output tests done");
        final_report;
    end
endmodule // tb_xbus_rtc_select_and_buffer_control
bind xbus_rtc_select_and_buffer_control xbus_ctl_chk xbus_ctl_chk_inst (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_suspend(i_suspend),
    .i_kbd_cpu_reset_request_n(i_kbd_cpu_reset_request_n), .i_ior_n(i_ior_n),
    .i_iow_n(i_iow_n), .i_memr_n(i_memr_n), .i_dma_read_ack_n(i_dma_read_ack_n),
    .i_addr(i_addr), .i_isa_master(i_isa_master), .i_firmware_rom_range(i_firmware_rom_range),
    .i_interrupt_controller_range(i_interrupt_controller_range),
    .i_gpo_sel_22(i_gpo_sel_22), .i_gpo_sel_24(i_gpo_sel_24), .i_gpo_sel_25(i_gpo_sel_25),
    .o_cpu_init(o_cpu_init), .o_clock_chip_index_strobe(o_clock_chip_index_strobe),
    .o_clock_chip_select_n(o_clock_chip_select_n),
    .o_periph_buffer_direction_n(o_periph_buffer_direction_n));
`default_nettype wire
